// *** hw/node_regs_defines.svh ***
// Register offsets, field positions, reset values and timing counts for the node register bank.
// Assumes inclusion from the design file and the testbench only.
`ifndef NODE_REGS_DEFINES_SVH
`define NODE_REGS_DEFINES_SVH

// Host addresses
`define OFS_STATUS      3'h0
`define OFS_DIAG        3'h1
`define OFS_PTR_HIGH    3'h2
`define OFS_PTR_LOW     3'h3
`define OFS_DATA        3'h4
`define OFS_BANK        3'h5
`define OFS_CONFIG      3'h6
`define OFS_BANKED      3'h7

// Bank selections at the banked address
`define SEL_PROBE       3'h0
`define SEL_OWN         3'h1
`define SEL_LINK_SETUP_ONE      3'h2
`define SEL_SUCC        3'h3
`define SEL_LINK_SETUP_TWO      3'h4

// Status, diagnostic and configuration bit positions
`define BIT_RI          7
`define BIT_POR         4
`define BIT_RECON       2
`define BIT_TA          0
`define BIT_SELFREC     7
`define BIT_DUPLICATE_IDENTIFIER_FLAG       6
`define BIT_EXCESS_NEGACK_FLAG      3
`define BIT_PROBE       2
`define BIT_SUCC        1
`define BIT_TRANSMIT_ENABLE_BIT        5
`define BIT_CFG_RESET   7

// Masks
`define IRQ_SOURCES     8'h8f
`define STATUS_DEF_MASK 8'h9f
`define DIAG_CLR_ON_RD  8'hf5
`define CFG_WR_MASK     8'hff
`define BANK_WR_MASK    8'hc7
`define LINK_SETUP_ONE_WR_MASK  8'hdf
`define LINK_SETUP_TWO_WR_MASK  8'h8f
`define PTRH_WR_MASK    8'hc7

// Reset values
`define ZERO8           8'h00
`define STATUS_RESET    8'h91
`define CONFIG_RESET    8'h18

// Commands
`define CMD_CLEAR_FLAGS 8'h1e
`define CMD_POR_CLEAR   8'h0e

// Sequencer timing
`define CORE_CLK_HZ     200000000
`define PC_CLK_HZ       625000
`define PC_DIV          (`CORE_CLK_HZ / `PC_CLK_HZ)
`define ROM_DEPTH       544
`define NOP_LOOP_TICKS  8'h04
`define OP_NOP          2'h0
`define OP_JUMP         2'h1
`define PC_ZERO         10'h000
`define RECON_TICKS     24'h100000

`endif

// *** hw/node_regs_pkg.sv ***
// Types shared by the node register bank.
// Assumes the defines header is available on the include path.
package node_regs_pkg;

    // Host register bus request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // Events reported by the protocol engine
    typedef struct packed {
        logic       ri_set;
        logic       ta_set;
        logic       duplicate_identifier_flag_set;
        logic       probe_hit;
        logic       excess_negack_flag_set;
        logic       succ_update;
        logic [7:0] succ_id;
    } proto_evt_t;

    typedef enum logic [1:0] {
        SEQ_SLEEP,
        SEQ_FETCH,
        SEQ_EXEC,
        SEQ_NOP_WAIT
    } seq_state_t;

endpackage

// *** hw/token_ring_node_regs_sequencer.sv ***
// Host register bank and protocol microsequencer of a token-passing node.
// Assumes host strobes are one-cycle pulses synchronous to core_clk.
`include "node_regs_defines.svh"

// Functional notes
// - Program counter steps at fast tick; execution happens every second tick.
// - Each fetch loads opcode and immediate registers from program ROM.
// - No-op runs a timed loop with the program counter held.
// - Jump loads the program counter with the ROM-supplied target.
// - Reconfig timer expiry clears program counter and sets self-reconfig flag.
// - Undefined bits read zero here; host writes zero there.
// - Mask bits share positions with their flags; one enables.
// - Only five flags may raise the interrupt.
// - Interrupt is OR of flags ANDed with mask; reappears on unmask.
// - Recon clears on clear-flags, excess negack on POR clear, successor on read.
// - Hardware reset clears the interrupt mask.
// - Data port transfers to RAM at the current pointer.
// - Writing pointer low prefetches RAM into the data port once.
// - Probe identifier is read/write, zero on hardware reset; match sets flag.
// - Zero own identifier keeps core asleep; nonzero wakes it.
// - No joining until transmit enable set; receiver stays working.
// - Successor register tracks next node; each update sets its flag.
// - Successor register clears on hardware or software reset.
// - Status takes its default pattern after hardware or software reset.
// - Diagnostic read clears flags except excess negack and successor flags.
// - Bank select picks register at address seven, selections zero to four.
// - Host writes pointer high then low; low loads the pointer.
module token_ring_node_regs_sequencer #(
    parameter int RAM_AW    = 11,
    parameter int ROM_DEPTH = `ROM_DEPTH,
    parameter int PC_DIV    = `PC_DIV,
    parameter int RECON_TICKS = `RECON_TICKS // Execution ticks to a recon timeout
) (
    input  wire logic                     core_clk,   // 200 MHz clock
    input  wire logic                     srst,       // Hardware reset
    input  wire node_regs_pkg::host_req_t host_req,   // Host strobes, address, data
    output logic [7:0]                    host_rdata, // Read data, registered
    output logic                          irq,        // Interrupt, active high
    input  wire node_regs_pkg::proto_evt_t proto_evt, // Protocol events
    input  wire logic [15:0]              rom_word,   // Opcode and immediate
    output logic [9:0]                    rom_addr,   // Program ROM address
    output logic                          ram_we,     // RAM write strobe
    output logic [RAM_AW-1:0]             ram_addr,   // RAM address
    output logic [7:0]                    ram_wdata,  // RAM write data
    input  wire logic [7:0]               ram_rdata,  // RAM read data, same cycle
    output logic                          core_awake, // Core running
    output logic                          tx_joined,  // Transmitter may join
    output logic [7:0]                    own_id      // Node identifier
);

    // ****************************************************************
    // Host decode
    // ****************************************************************
    logic [7:0] mask_reg, diag_reg, status_reg, cfg_reg, bank_reg;
    logic [7:0] probe_reg, own_reg, link_setup_one_reg, link_setup_two_reg, succ_reg;
    logic [7:0] ptrh_reg, ptrl_reg, data_reg;
    logic [RAM_AW-1:0] ptr_reg;
    logic       soft_rst;
    logic [2:0] sel;

    // Write strobe for one host address
    function automatic logic hwr(input logic [2:0] a);
        hwr = host_req.wr && (host_req.addr == a);
    endfunction

    // Read strobe for one host address
    function automatic logic hrd(input logic [2:0] a);
        hrd = host_req.rd && (host_req.addr == a);
    endfunction

    assign sel      = bank_reg[2:0];
    assign soft_rst = cfg_reg[`BIT_CFG_RESET];
    wire   cmd_clr  = hwr(`OFS_DIAG) && (host_req.wdata == `CMD_CLEAR_FLAGS);
    wire   cmd_por  = hwr(`OFS_DIAG) && (host_req.wdata == `CMD_POR_CLEAR);
    wire   succ_rd  = hrd(`OFS_BANKED) && (sel == `SEL_SUCC);
    logic  recon_fire;

    // ****************************************************************
    // Mask, configuration and banked registers
    // ****************************************************************
    // Mask is write-only; undefined bits kept zero so they never gate
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mask_reg <= `ZERO8;
        end else if (hwr(`OFS_STATUS)) begin
            mask_reg <= host_req.wdata & `IRQ_SOURCES;
        end
    end

    // Configuration and bank select; config writes clear bank bit 2
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_reg  <= `CONFIG_RESET;
            bank_reg <= `ZERO8;
        end else if (hwr(`OFS_CONFIG)) begin
            cfg_reg  <= host_req.wdata & `CFG_WR_MASK;
            bank_reg <= {bank_reg[7:6], 4'h0, host_req.wdata[1:0]};
        end else if (hwr(`OFS_BANK)) begin
            bank_reg <= host_req.wdata & `BANK_WR_MASK;
            cfg_reg  <= {cfg_reg[7:2], host_req.wdata[1:0]};
        end
    end

    // Banked identifier and setup registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            probe_reg  <= `ZERO8;
            own_reg    <= `ZERO8;
            link_setup_one_reg <= `ZERO8;
            link_setup_two_reg <= `ZERO8;
        end else if (hwr(`OFS_BANKED)) begin
            unique case (sel)
                `SEL_PROBE:  probe_reg  <= host_req.wdata;
                `SEL_OWN:    own_reg    <= host_req.wdata;
                `SEL_LINK_SETUP_ONE: link_setup_one_reg <= host_req.wdata & `LINK_SETUP_ONE_WR_MASK;
                `SEL_LINK_SETUP_TWO: link_setup_two_reg <= host_req.wdata & `LINK_SETUP_TWO_WR_MASK;
                default: ;
            endcase
        end
    end

    // Successor identifier: protocol updates win over nothing; read-only to host
    always_ff @(posedge core_clk) begin
        if (srst || soft_rst) begin
            succ_reg <= `ZERO8;
        end else if (proto_evt.succ_update) begin
            succ_reg <= proto_evt.succ_id;
        end
    end

    // ****************************************************************
    // Status and diagnostic flags
    // ****************************************************************
    // Set wins over clear so a same-cycle event is never lost
    always_ff @(posedge core_clk) begin
        if (srst || soft_rst) begin
            status_reg <= `STATUS_RESET & `STATUS_DEF_MASK;
        end else begin
            if (proto_evt.ri_set) status_reg[`BIT_RI] <= 1'b1;
            if (proto_evt.ta_set) status_reg[`BIT_TA] <= 1'b1;
            if (recon_fire) begin
                status_reg[`BIT_RECON] <= 1'b1;
            end else if (cmd_clr) begin
                status_reg[`BIT_RECON] <= 1'b0;
            end
            if (hwr(`OFS_BANKED) && sel == `SEL_OWN && host_req.wdata == `ZERO8) begin
                status_reg[`BIT_POR] <= 1'b1;
            end else if (cmd_clr || cmd_por) begin
                status_reg[`BIT_POR] <= 1'b0;
            end
        end
    end

    logic [7:0] diag_set;
    always_comb begin
        diag_set = `ZERO8;
        diag_set[`BIT_SELFREC] = recon_fire;
        diag_set[`BIT_DUPLICATE_IDENTIFIER_FLAG]   = proto_evt.duplicate_identifier_flag_set;
        diag_set[`BIT_PROBE]   = proto_evt.probe_hit;
        diag_set[`BIT_EXCESS_NEGACK_FLAG]  = proto_evt.excess_negack_flag_set;
        diag_set[`BIT_SUCC]    = proto_evt.succ_update;
    end

    // Clear requests for the diagnostic flags, kept out of the flop
    logic [7:0] diag_clr;
    always_comb begin
        diag_clr = `ZERO8;
        if (hrd(`OFS_DIAG)) diag_clr = diag_clr | `DIAG_CLR_ON_RD;
        if (cmd_por) diag_clr[`BIT_EXCESS_NEGACK_FLAG] = 1'b1;
        if (succ_rd) diag_clr[`BIT_SUCC] = 1'b1;
    end

    // Diagnostic read clears most flags; excess negack and successor kept
    always_ff @(posedge core_clk) begin
        if (srst || soft_rst) begin
            diag_reg <= `ZERO8;
        end else begin
            diag_reg <= (diag_reg & ~diag_clr) | diag_set;
        end
    end

    // Five sources only; each meets its mask bit in the same position
    wire [7:0] irq_flags = {status_reg[`BIT_RI], 3'h0, diag_reg[`BIT_EXCESS_NEGACK_FLAG],
                            status_reg[`BIT_RECON], diag_reg[`BIT_SUCC], status_reg[`BIT_TA]};
    assign irq = |(irq_flags & mask_reg & `IRQ_SOURCES);

    // ****************************************************************
    // RAM pointer and data port
    // ****************************************************************
    // Pointer loads whole only on the low-byte write, so high goes first
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ptrh_reg <= `ZERO8;
            ptrl_reg <= `ZERO8;
            ptr_reg  <= '0;
        end else begin
            if (hwr(`OFS_PTR_HIGH)) ptrh_reg <= host_req.wdata & `PTRH_WR_MASK;
            if (hwr(`OFS_PTR_LOW)) begin
                ptrl_reg <= host_req.wdata;
                ptr_reg  <= RAM_AW'({ptrh_reg[2:0], host_req.wdata});
            end
        end
    end

    // Data port: prefetch on low-byte write, write-through on data write
    assign ram_addr  = hwr(`OFS_PTR_LOW)
                     ? RAM_AW'({ptrh_reg[2:0], host_req.wdata}) : ptr_reg;
    assign ram_we    = hwr(`OFS_DATA);
    assign ram_wdata = host_req.wdata;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_reg <= `ZERO8;
        end else if (hwr(`OFS_PTR_LOW)) begin
            data_reg <= ram_rdata;
        end else if (hwr(`OFS_DATA)) begin
            data_reg <= host_req.wdata;
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Undefined bits answer zero, a legal choice for undefined
    always_ff @(posedge core_clk) begin
        if (srst) begin
            host_rdata <= `ZERO8;
        end else if (host_req.rd) begin
            unique case (host_req.addr)
                `OFS_STATUS:   host_rdata <= status_reg;
                `OFS_DIAG:     host_rdata <= diag_reg;
                `OFS_PTR_HIGH: host_rdata <= ptrh_reg;
                `OFS_PTR_LOW:  host_rdata <= ptrl_reg;
                `OFS_DATA:     host_rdata <= data_reg;
                `OFS_BANK:     host_rdata <= bank_reg;
                `OFS_CONFIG:   host_rdata <= cfg_reg;
                `OFS_BANKED: begin
                    unique case (sel)
                        `SEL_PROBE:  host_rdata <= probe_reg;
                        `SEL_OWN:    host_rdata <= own_reg;
                        `SEL_LINK_SETUP_ONE: host_rdata <= link_setup_one_reg;
                        `SEL_SUCC:   host_rdata <= succ_reg;
                        `SEL_LINK_SETUP_TWO: host_rdata <= link_setup_two_reg;
                        default:     host_rdata <= `ZERO8;
                    endcase
                end
            endcase
        end
    end

    // ****************************************************************
    // Microsequencer
    // ****************************************************************
    localparam int DW = $clog2(PC_DIV);
    node_regs_pkg::seq_state_t seq_reg;
    logic [DW-1:0] div_reg;
    logic          half_reg, fast_tick, exec_tick;
    logic [9:0]    pc_reg;
    logic [7:0]    op_reg, imm_reg, nop_reg;
    logic [23:0]   recon_reg;

    assign own_id     = own_reg;
    assign core_awake = (own_reg != `ZERO8);
    assign tx_joined  = core_awake && cfg_reg[`BIT_TRANSMIT_ENABLE_BIT];
    assign rom_addr   = pc_reg;
    assign fast_tick  = (div_reg == DW'(PC_DIV - 1));
    assign exec_tick  = fast_tick && half_reg;

    // Fast tick divider and half-rate phase
    always_ff @(posedge core_clk) begin
        if (srst || !core_awake) begin
            div_reg  <= '0;
            half_reg <= 1'b0;
        end else if (fast_tick) begin
            div_reg  <= '0;
            half_reg <= ~half_reg;
        end else begin
            div_reg <= div_reg + DW'(1);
        end
    end

    // Reconfiguration timer counts execution ticks while awake
    assign recon_fire = core_awake && exec_tick && (recon_reg == 24'(RECON_TICKS));
    always_ff @(posedge core_clk) begin
        if (srst || !core_awake || recon_fire || proto_evt.succ_update) begin
            recon_reg <= '0;
        end else if (exec_tick) begin
            recon_reg <= recon_reg + 24'h1;
        end
    end

    // Fetch on the fast tick, execute on the slow one
    always_ff @(posedge core_clk) begin
        if (srst) begin
            seq_reg <= node_regs_pkg::SEQ_SLEEP;
            pc_reg  <= `PC_ZERO;
            op_reg  <= `ZERO8;
            imm_reg <= `ZERO8;
            nop_reg <= `ZERO8;
        end else if (!core_awake) begin
            seq_reg <= node_regs_pkg::SEQ_SLEEP;
        end else if (recon_fire) begin
            pc_reg  <= `PC_ZERO;
            seq_reg <= node_regs_pkg::SEQ_FETCH;
        end else if (fast_tick) begin
            unique case (seq_reg)
                node_regs_pkg::SEQ_SLEEP: seq_reg <= node_regs_pkg::SEQ_FETCH;
                node_regs_pkg::SEQ_FETCH: begin
                    op_reg  <= rom_word[15:8];
                    imm_reg <= rom_word[7:0];
                    seq_reg <= node_regs_pkg::SEQ_EXEC;
                end
                node_regs_pkg::SEQ_EXEC: if (half_reg) begin
                    if (op_reg[1:0] == `OP_NOP) begin
                        nop_reg <= `NOP_LOOP_TICKS;
                        seq_reg <= node_regs_pkg::SEQ_NOP_WAIT;
                    end else if (op_reg[1:0] == `OP_JUMP) begin
                        pc_reg  <= {op_reg[7:6], imm_reg};
                        seq_reg <= node_regs_pkg::SEQ_FETCH;
                    end else begin
                        pc_reg  <= (pc_reg == 10'(ROM_DEPTH - 1)) ? `PC_ZERO : pc_reg + 10'h1;
                        seq_reg <= node_regs_pkg::SEQ_FETCH;
                    end
                end
                node_regs_pkg::SEQ_NOP_WAIT: begin
                    if (nop_reg == `ZERO8) begin
                        pc_reg  <= pc_reg + 10'h1;
                        seq_reg <= node_regs_pkg::SEQ_FETCH;
                    end else begin
                        nop_reg <= nop_reg - 8'h1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Five sources summed bit by bit, apart from the packed flag vector
    wire five_src = (status_reg[`BIT_RI] && mask_reg[`BIT_RI])
                 || (status_reg[`BIT_TA] && mask_reg[`BIT_TA])
                 || (status_reg[`BIT_RECON] && mask_reg[`BIT_RECON])
                 || (diag_reg[`BIT_EXCESS_NEGACK_FLAG] && mask_reg[`BIT_EXCESS_NEGACK_FLAG])
                 || (diag_reg[`BIT_SUCC] && mask_reg[`BIT_SUCC]);
    a_mask_reset: assert property (@(posedge core_clk) srst |=> mask_reg == `ZERO8)
        else $error("mask not cleared by reset");
    a_irq_gating: assert property (@(posedge core_clk) disable iff (srst)
        irq == five_src)
        else $error("interrupt not OR of masked flags");
    a_only_five: assert property (@(posedge core_clk) disable iff (srst)
        irq |-> five_src)
        else $error("interrupt from a non-source flag");
    a_succ_clear: assert property (@(posedge core_clk) disable iff (srst)
        succ_rd && !proto_evt.succ_update |=> !diag_reg[`BIT_SUCC])
        else $error("successor flag not cleared by read");
    a_excess_negack_flag_keep: assert property (@(posedge core_clk) disable iff (srst || soft_rst)
        hrd(`OFS_DIAG) && !cmd_por && diag_reg[`BIT_EXCESS_NEGACK_FLAG] |=> diag_reg[`BIT_EXCESS_NEGACK_FLAG])
        else $error("excess negack lost on diagnostic read");
    a_sleep_hold: assert property (@(posedge core_clk) disable iff (srst)
        !core_awake |=> $stable(pc_reg))
        else $error("program counter moved while asleep");
    a_recon_pc: assert property (@(posedge core_clk) disable iff (srst)
        recon_fire |=> pc_reg == `PC_ZERO && diag_reg[`BIT_SELFREC])
        else $error("recon did not clear pc and set flag");
    a_prefetch: assert property (@(posedge core_clk) disable iff (srst)
        hwr(`OFS_PTR_LOW) |=> data_reg == $past(ram_rdata))
        else $error("data port not prefetched");
    a_nop_hold: assert property (@(posedge core_clk) disable iff (srst || recon_fire)
        seq_reg == node_regs_pkg::SEQ_NOP_WAIT && nop_reg != `ZERO8 |=> $stable(pc_reg))
        else $error("pc moved during no-op loop");
    a_succ_status: assert property (@(posedge core_clk) disable iff (srst)
        soft_rst |=> succ_reg == `ZERO8 && status_reg == `STATUS_RESET)
        else $error("soft reset defaults wrong");

endmodule

// *** testbench/node_mem_model.sv ***
// Program ROM and shared RAM model on the far side of the node register bank.
// Assumes reads follow the address in the same cycle, writes land on the edge.
module node_mem_model #(
    parameter int RAM_AW = 11
) (
    input  wire logic              core_clk,  // Bank clock
    input  wire logic [9:0]        rom_addr,  // Program counter
    output logic [15:0]            rom_word,  // Opcode and immediate
    input  wire logic              ram_we,    // Write strobe
    input  wire logic [RAM_AW-1:0] ram_addr,  // RAM address
    input  wire logic [7:0]        ram_wdata, // Write data
    output logic [7:0]             ram_rdata  // Read data, same cycle
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:(1<<RAM_AW)-1];
    // **********************************************
    // Program: step, no-op, step, jump back to zero
    // **********************************************
    always_comb begin
        case (rom_addr)
            10'h001: rom_word = 16'h0000;
            10'h003: rom_word = 16'h0100;
            default: rom_word = 16'h0200;
        endcase
    end
    // Unwritten bytes carry an address pattern so a stale read cannot pass
    initial begin
        for (int i = 0; i < (1 << RAM_AW); i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
    end
    always @(posedge core_clk) begin
        if (ram_we) begin
            mem[ram_addr] <= ram_wdata;
        end
    end
    assign ram_rdata = mem[ram_addr];
endmodule

// *** testbench/tb_token_ring_node_regs_sequencer.sv ***
// Self-checking bench for the node register bank and microsequencer.
// Assumes single-cycle host strobes and the memory model beside the bank.
`include "node_regs_defines.svh"
module tb_token_ring_node_regs_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic                      core_clk, srst, irq, ram_we, core_awake, tx_joined;
    node_regs_pkg::host_req_t  host_req;
    node_regs_pkg::proto_evt_t proto_evt;
    logic [7:0]                host_rdata, ram_wdata, ram_rdata, own_id;
    logic [15:0]               rom_word;
    logic [9:0]                rom_addr;
    logic [10:0]               ram_addr;
    int                        fail_count, n_checks;
    // Short divider keeps the sequencer loop within a few hundred cycles
    token_ring_node_regs_sequencer #(.RAM_AW(11), .PC_DIV(4), .RECON_TICKS(64)) dut (
        .core_clk(core_clk), .srst(srst), .host_req(host_req), .host_rdata(host_rdata),
        .irq(irq), .proto_evt(proto_evt), .rom_word(rom_word), .rom_addr(rom_addr),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .core_awake(core_awake), .tx_joined(tx_joined),
        .own_id(own_id));
    node_mem_model #(.RAM_AW(11)) u_mem (
        .core_clk(core_clk), .rom_addr(rom_addr), .rom_word(rom_word), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
    // ******************
    // Host access tasks
    // ******************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Each access waits an edge first, so strobes never toggle twice in a step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        host_req.addr = a;
        host_req.wdata = d;
        host_req.wr = 1'b1;
        @(posedge core_clk);
        #1;
        host_req.wr = 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        #1;
        host_req.addr = a;
        host_req.rd = 1'b1;
        @(posedge core_clk);
        #1;
        host_req.rd = 1'b0;
        check(what, host_rdata, exp);
    endtask
    task automatic ev(input node_regs_pkg::proto_evt_t e);
        @(posedge core_clk);
        #1;
        proto_evt = e;
        @(posedge core_clk);
        #1;
        proto_evt = '0;
    endtask
    // Bounded wait on the program counter; running out ends the run
    task automatic wait_pc(input logic [9:0] target);
        int n;
        n = 0;
        while (rom_addr !== target && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("rom_addr", rom_addr[7:0], target[7:0]);
        if (rom_addr !== target) end_sim();
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // *********************
    // Clock and test flow
    // *********************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        srst = 1'b1;
        host_req = '0;
        proto_evt = '0;
        fail_count = 0;
        n_checks = 0;
        repeat (12) @(posedge core_clk);
        #1;
        srst = 1'b0;
        // Defaults after hardware reset; sequencer must sleep
        rdc(`OFS_STATUS, `STATUS_RESET, "status");
        rdc(`OFS_DIAG, 8'h00, "diag");
        check("irq", irq, 8'h00);
        repeat (20) @(posedge core_clk);
        check("rom_addr", rom_addr[7:0], 8'h00);
        check("core_awake", core_awake, 8'h00);
        // Banked registers: defaults, write-back and refused successor write
        wr(`OFS_BANK, `SEL_PROBE);
        rdc(`OFS_BANKED, 8'h00, "probe");
        wr(`OFS_BANKED, 8'h33);
        rdc(`OFS_BANKED, 8'h33, "probe");
        wr(`OFS_BANK, `SEL_SUCC);
        wr(`OFS_BANKED, 8'h77);
        rdc(`OFS_BANKED, 8'h00, "successor");
        wr(`OFS_BANK, `SEL_LINK_SETUP_ONE);
        wr(`OFS_BANKED, 8'h11);
        rdc(`OFS_BANKED, 8'h11, "link_setup_one");
        wr(`OFS_BANK, `SEL_LINK_SETUP_TWO);
        wr(`OFS_BANKED, 8'h03);
        rdc(`OFS_BANKED, 8'h03, "link_setup_two");
        wr(`OFS_BANK, `SEL_OWN);
        wr(`OFS_BANKED, 8'h2a);
        check("own_id", own_id, 8'h2a);
        check("core_awake", core_awake, 8'h01);
        check("tx_joined", tx_joined, 8'h00);
        // Awake sequencer walks the program and takes the jump home
        wait_pc(10'h003);
        wait_pc(10'h000);
        wr(`OFS_CONFIG, 8'h38);
        check("tx_joined", tx_joined, 8'h01);
        // Mask against the RI and TA flags left set by reset
        wr(`OFS_STATUS, 8'h80);
        check("irq ri", irq, 8'h01);
        wr(`OFS_STATUS, 8'h00);
        check("irq off", irq, 8'h00);
        wr(`OFS_STATUS, 8'h80);
        check("irq ri again", irq, 8'h01);
        wr(`OFS_STATUS, 8'h01);
        check("irq ta", irq, 8'h01);
        // Duplicate-id flag may never interrupt, and clears on read
        wr(`OFS_STATUS, 8'h40);
        ev('{duplicate_identifier_flag_set: 1'b1, default: '0});
        check("irq duplicate_identifier_flag", irq, 8'h00);
        // Successor update raises its flag and survives a diag read
        wr(`OFS_STATUS, 8'h02);
        ev('{succ_update: 1'b1, succ_id: 8'h5a, default: '0});
        check("irq succ", irq, 8'h01);
        rdc(`OFS_DIAG, 8'h42, "diag");
        rdc(`OFS_DIAG, 8'h02, "diag");
        wr(`OFS_BANK, `SEL_SUCC);
        rdc(`OFS_BANKED, 8'h5a, "successor");
        check("irq succ read", irq, 8'h00);
        // Excess negack outlives diag reads and plain clear-flags
        wr(`OFS_STATUS, 8'h08);
        ev('{excess_negack_flag_set: 1'b1, default: '0});
        rdc(`OFS_DIAG, 8'h08, "diag");
        wr(`OFS_DIAG, `CMD_CLEAR_FLAGS);
        check("irq excess_negack_flag", irq, 8'h01);
        rdc(`OFS_STATUS, 8'h81, "status");
        wr(`OFS_DIAG, `CMD_POR_CLEAR);
        check("irq excess_negack_flag clr", irq, 8'h00);
        // RAM: high then low, write through data, prefetch on low write
        wr(`OFS_PTR_HIGH, 8'h01);
        wr(`OFS_PTR_LOW, 8'h23);
        wr(`OFS_DATA, 8'ha5);
        check("ram byte", u_mem.mem[11'h123], 8'ha5);
        wr(`OFS_PTR_LOW, 8'h23);
        rdc(`OFS_DATA, 8'ha5, "data");
        wr(`OFS_PTR_LOW, 8'h24);
        rdc(`OFS_DATA, 8'h7e, "data");
        // Software reset restores status and successor, not the probe id
        wr(`OFS_CONFIG, 8'h83);
        wr(`OFS_CONFIG, 8'h03);
        rdc(`OFS_STATUS, `STATUS_RESET, "status");
        rdc(`OFS_BANKED, 8'h00, "successor");
        wr(`OFS_BANK, `SEL_PROBE);
        rdc(`OFS_BANKED, 8'h33, "probe");
        // Short recon timeout: pc home, self-reconfig flag, clear-flags drops the recon flag
        wr(`OFS_STATUS, 8'h04);
        for (int n = 0; n < 1000 && irq !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check("irq recon", irq, 8'h01);
        if (irq !== 1'b1) end_sim();
        check("rom_addr", rom_addr[7:0], 8'h00);
        rdc(`OFS_DIAG, 8'h80, "diag");
        wr(`OFS_DIAG, `CMD_CLEAR_FLAGS);
        check("irq recon clr", irq, 8'h00);
        end_sim();
    end
endmodule
